//--- hdl/mdsb_defines.svh
// Purpose: constants of the mode-dependent status bit block
// Assumes: included by bare name; definitions only
// Notes: mode codes are 8-bit, status words 16-bit
`ifndef MDSB_DEFINES_SVH
`define MDSB_DEFINES_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define MDSB_STATUS_WORD_OFS 16'h6041
`define MDSB_STATUS_EXT_OFS 16'h4000

// ----------------------------------------
// mode codes
// ----------------------------------------
`define MDSB_MODE_NONE 8'h00
`define MDSB_MODE_PP 8'h01
`define MDSB_MODE_HM 8'h06
`define MDSB_MODE_CSP 8'h08
`define MDSB_MODE_CSV 8'h09
`define MDSB_MODE_CST 8'h0a

// ----------------------------------------
// status word bit positions
// ----------------------------------------
`define MDSB_SW_REMOTE 9
`define MDSB_SW_B10 10
`define MDSB_SW_B12 12
`define MDSB_SW_B13 13

// ----------------------------------------
// extension word bit positions
// ----------------------------------------
`define MDSB_EX_DONE 1
`define MDSB_EX_LIMIT 4
`define MDSB_EX_VMATCH 7
`define MDSB_EX_CLOSE 8

// ----------------------------------------
// reset values
// ----------------------------------------
`define MDSB_STATUS_WORD_RST 16'h0200
`define MDSB_STATUS_EXT_RST 16'h0102
`define MDSB_MODE_RST 8'h00

`endif

//--- hdl/mdsb_pkg.sv
// Purpose: shared types of the mode-dependent status bit block
// Assumes: nothing imported by users
// Notes: constants live in mdsb_defines.svh
package mdsb_pkg;

	// drive sequence states
	typedef enum logic [1:0] {
		ST_OFF,
		ST_RUN,
		ST_STOP,
		ST_FAULT
	} mdsb_state_t;

	// grouping of the displayed mode
	typedef enum logic [2:0] {
		CL_NONE,
		CL_PP,
		CL_HM,
		CL_CSP,
		CL_CSV,
		CL_CST
	} mdsb_class_t;

	// raw status sources from the motion core
	typedef struct packed {
		logic targetReached;
		logic setpointAck;
		logic followingError;
		logic targetIgnored;
		logic homeAttained;
		logic homingError;
		logic motionDone;
		logic positionClose;
		logic speedLimitActive;
		logic speedMatch;
	} mdsb_src_t;

	// stop causes seen by the drive
	typedef struct packed {
		logic servoOn;
		logic drivePermit;
		logic mainPowerOk;
		logic faultActive;
		logic homingRunning;
	} mdsb_cause_t;

endpackage : mdsb_pkg

//--- hdl/mdsb_status_bits.sv
// Purpose: mode-dependent status word and extension word generation
// Assumes: all inputs synchronous to ref_clk; master writes legal modes
// Notes: words are read by the fieldbus side straight from the ports
`timescale 1ns/1ps
`include "mdsb_defines.svh"

// How it works
// - pp/hm select bits 10, 12, 13; csp bits 12, 13 only
// - csv/cst show target-ignored, bits 10/13 zero
// - position modes show done and close flags
// - speed limit in cst, speed match in csv
// - no mode: zeros, done and close ones
// - not following: cyclic modes bit 12 zero
// - not following: speed limit and match zero
// - not following in homing: hold homing bits
// - servo off starts stop, mode still shown
// - at rest display becomes no mode
// - servo-off decel in cyclic modes: bit 12 zero
// - velocity/torque force foreign bits zero
// - prohibition and power loss stop like servo off, but prohibition keeps operation enabled
// - homing run ignores drive prohibition stop
// - remote bit 9 stays one
// - servo off drops operation enabled to switched-on
// - commanded mode kept after servo-off stop
// - legal mode codes 0,1,6,8,9,10 only
// - fault states display mode zero
module mdsb_status_bits #(
	parameter int SPEED_W = 16
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic clkEn,
	// commanded mode write from the master
	input wire logic modeWrite,
	input wire logic [7:0] modeWriteData,
	// drive condition inputs
	input wire mdsb_pkg::mdsb_cause_t cause,
	input wire mdsb_pkg::mdsb_src_t src,
	input wire logic [SPEED_W-1:0] speedAbs,
	input wire logic [SPEED_W-1:0] restThreshold,
	// readable words
	output logic [15:0] driveStatusWord,
	output logic [15:0] driveStatusExtension,
	output logic [7:0] commandedMode,
	output logic [7:0] displayedMode,
	// drive sequence state
	output logic opEnabled,
	output logic decelStop
);

	// ----------------------------------------
	// helpers
	// ----------------------------------------

	// decode a mode code; unknown codes behave as no mode
	function automatic mdsb_pkg::mdsb_class_t modeClass(input logic [7:0] m);
		mdsb_pkg::mdsb_class_t c;
		c = mdsb_pkg::CL_NONE;
		if (m == `MDSB_MODE_PP) c = mdsb_pkg::CL_PP;
		else if (m == `MDSB_MODE_HM) c = mdsb_pkg::CL_HM;
		else if (m == `MDSB_MODE_CSP) c = mdsb_pkg::CL_CSP;
		else if (m == `MDSB_MODE_CSV) c = mdsb_pkg::CL_CSV;
		else if (m == `MDSB_MODE_CST) c = mdsb_pkg::CL_CST;
		return c;
	endfunction : modeClass

	// position modes own the done and close flags; used only for the extension done and close bits
	function automatic logic isPosition(input mdsb_pkg::mdsb_class_t c);
		return c == mdsb_pkg::CL_CSP || c == mdsb_pkg::CL_PP || c == mdsb_pkg::CL_HM;
	endfunction : isPosition

	// ----------------------------------------
	// state
	// ----------------------------------------
	mdsb_pkg::mdsb_state_t state_reg;
	mdsb_pkg::mdsb_state_t state_next;
	logic [7:0] cmdMode_reg;
	logic [7:0] cmdMode_next;
	logic [7:0] dispMode_reg;
	logic [7:0] dispMode_next;
	logic homeAtt_reg;
	logic homeAtt_next;
	logic homeErr_reg;
	logic homeErr_next;
	logic [15:0] word_reg;
	logic [15:0] word_next;
	logic [15:0] ext_reg;
	logic [15:0] ext_next;
	logic opEn_reg;
	logic opEn_next;
	logic decel_reg;
	logic decel_next;

	// combinational helpers
	mdsb_pkg::mdsb_class_t cmdClass;
	mdsb_pkg::mdsb_class_t dispClass;
	logic permitEff;
	logic stopCause;
	logic atRest;
	logic following;

	// ----------------------------------------
	// stop causes
	// ----------------------------------------

	// prohibition is masked during a homing run so homing can reverse
	assign cmdClass = modeClass(cmdMode_reg);
	assign permitEff = cause.drivePermit |
		(cmdClass == mdsb_pkg::CL_HM && cause.homingRunning);
	assign stopCause = !cause.servoOn || !cause.mainPowerOk || !permitEff;
	assign atRest = speedAbs < restThreshold;

	// ----------------------------------------
	// sequence and mode registers
	// ----------------------------------------

	// fault wins over everything; stop ends only once the motor rests
	always_comb begin
		state_next = state_reg;
		cmdMode_next = cmdMode_reg;
		if (modeWrite) begin
			cmdMode_next = modeWriteData;
		end
		unique case (state_reg)
			mdsb_pkg::ST_OFF: begin
				if (!stopCause) state_next = mdsb_pkg::ST_RUN;
			end
			mdsb_pkg::ST_RUN: begin
				if (stopCause) state_next = mdsb_pkg::ST_STOP;
			end
			mdsb_pkg::ST_STOP: begin
				if (atRest) state_next = mdsb_pkg::ST_OFF;
			end
			mdsb_pkg::ST_FAULT: begin
				if (!cause.faultActive) state_next = mdsb_pkg::ST_OFF;
			end
		endcase
		if (cause.faultActive) begin
			state_next = mdsb_pkg::ST_FAULT;
		end
	end

	// displayed mode follows the next state so word and mode agree
	always_comb begin
		unique case (state_next)
			mdsb_pkg::ST_RUN,
			mdsb_pkg::ST_STOP: dispMode_next = cmdMode_next;
			mdsb_pkg::ST_OFF: dispMode_next = `MDSB_MODE_NONE;
			mdsb_pkg::ST_FAULT: dispMode_next = `MDSB_MODE_NONE;
		endcase
	end

	// servo off leaves operation enabled at once; prohibition keeps servo on
	always_comb begin
		opEn_next = (state_next == mdsb_pkg::ST_RUN) ||
			(state_next == mdsb_pkg::ST_STOP && cause.servoOn &&
			cause.mainPowerOk);
		decel_next = state_next == mdsb_pkg::ST_STOP;
	end

	// ----------------------------------------
	// status bit selection
	// ----------------------------------------

	// bits are built from the next displayed mode so all words move together
	assign dispClass = modeClass(dispMode_next);
	assign following = state_next == mdsb_pkg::ST_RUN;

	// homing bits are sampled only while commands are followed, else held
	always_comb begin
		homeAtt_next = homeAtt_reg;
		homeErr_next = homeErr_reg;
		if (following && dispClass == mdsb_pkg::CL_HM) begin
			homeAtt_next = src.homeAttained;
			homeErr_next = src.homingError;
		end
	end

	// one word pair per cycle; anything the mode does not own stays zero, except remote bit 9, which stays one
	always_comb begin
		word_next = 16'h0000;
		ext_next = 16'h0000;
		word_next[`MDSB_SW_REMOTE] = 1'b1;
		unique case (dispClass)
			mdsb_pkg::CL_CSP: begin
				word_next[`MDSB_SW_B12] = src.targetIgnored & following;
				word_next[`MDSB_SW_B13] = src.followingError;
			end
			mdsb_pkg::CL_PP: begin
				word_next[`MDSB_SW_B10] = src.targetReached;
				word_next[`MDSB_SW_B12] = src.setpointAck;
				word_next[`MDSB_SW_B13] = src.followingError;
			end
			mdsb_pkg::CL_HM: begin
				word_next[`MDSB_SW_B10] = src.targetReached;
				word_next[`MDSB_SW_B12] = homeAtt_next;
				word_next[`MDSB_SW_B13] = homeErr_next;
			end
			mdsb_pkg::CL_CSV: begin
				word_next[`MDSB_SW_B12] = src.targetIgnored & following;
				ext_next[`MDSB_EX_VMATCH] = src.speedMatch & following;
			end
			mdsb_pkg::CL_CST: begin
				word_next[`MDSB_SW_B12] = src.targetIgnored & following;
				ext_next[`MDSB_EX_LIMIT] = src.speedLimitActive & following;
			end
			mdsb_pkg::CL_NONE: begin
				ext_next[`MDSB_EX_DONE] = 1'b1;
				ext_next[`MDSB_EX_CLOSE] = 1'b1;
			end
		endcase
		// done and close follow the sources only in the position modes; no mode shows ones, others zero
		if (isPosition(dispClass)) begin
			ext_next[`MDSB_EX_DONE] = src.motionDone;
			ext_next[`MDSB_EX_CLOSE] = src.positionClose;
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------

	// sequence group; clock enable freezes every flip-flop
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_reg <= mdsb_pkg::ST_OFF;
			cmdMode_reg <= `MDSB_MODE_RST;
			dispMode_reg <= `MDSB_MODE_RST;
			opEn_reg <= 1'b0;
			decel_reg <= 1'b0;
		end else if (clkEn) begin
			state_reg <= state_next;
			cmdMode_reg <= cmdMode_next;
			dispMode_reg <= dispMode_next;
			opEn_reg <= opEn_next;
			decel_reg <= decel_next;
		end
	end

	// homing memory group; reads zero until a homing run has reported
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			homeAtt_reg <= 1'b0;
			homeErr_reg <= 1'b0;
		end else if (clkEn) begin
			homeAtt_reg <= homeAtt_next;
			homeErr_reg <= homeErr_next;
		end
	end

	// status word group; registered so the master never sees a half update
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			word_reg <= `MDSB_STATUS_WORD_RST;
			ext_reg <= `MDSB_STATUS_EXT_RST;
		end else if (clkEn) begin
			word_reg <= word_next;
			ext_reg <= ext_next;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign driveStatusWord = word_reg;
	assign driveStatusExtension = ext_reg;
	assign commandedMode = cmdMode_reg;
	assign displayedMode = dispMode_reg;
	assign opEnabled = opEn_reg;
	assign decelStop = decel_reg;

endmodule : mdsb_status_bits

//--- bench/mdsb_master_model.sv
// Purpose: fieldbus master side, writes the commanded mode
// Assumes: tb asks for a write with a one-cycle req
// Notes: data line shows garbage outside a write
`timescale 1ns/1ps
module mdsb_master_model (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// request from the bench
	input wire logic req,
	input wire logic [7:0] reqMode,
	// write to the drive
	output logic modeWrite,
	output logic [7:0] modeWriteData
);
	// launch on the edge; data inverted between writes so stale codes are never reused
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			modeWrite <= 1'b0;
			modeWriteData <= 8'h00;
		end else begin
			modeWrite <= req;
			modeWriteData <= req ? reqMode : ~modeWriteData;
		end
	end
endmodule : mdsb_master_model

//--- bench/mdsb_status_bits_monitor.sv
// Purpose: port checker of the mode-dependent status bits
// Assumes: single clock domain
// Notes: run means operation enabled with no stop pending
`timescale 1ns/1ps
module mdsb_status_bits_monitor #(
	parameter int SPEED_W = 16
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic clkEn,
	// inputs
	input wire logic modeWrite,
	input wire logic [7:0] modeWriteData,
	input wire mdsb_pkg::mdsb_cause_t cause,
	input wire mdsb_pkg::mdsb_src_t src,
	input wire logic [SPEED_W-1:0] speedAbs,
	input wire logic [SPEED_W-1:0] restThreshold,
	// outputs
	input wire logic [15:0] driveStatusWord,
	input wire logic [15:0] driveStatusExtension,
	input wire logic [7:0] commandedMode,
	input wire logic [7:0] displayedMode,
	input wire logic opEnabled,
	input wire logic decelStop
);
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	logic run;
	logic [15:0] w;
	logic [15:0] x;
	// a mode write at the same edge would move the display, so leave it out
	assign run = opEnabled && !decelStop && clkEn && !modeWrite && !cause.faultActive;
	assign w = driveStatusWord;
	assign x = driveStatusExtension;
	property p_remote; w[9]; endproperty
	a_remote: assert property (p_remote) else $error("remote bit low");
	property p_none; displayedMode == 8'h00 |-> w == 16'h0200 && x == 16'h0102; endproperty
	a_none: assert property (p_none) else $error("no-mode bits wrong");
	property p_vel; displayedMode == 8'h09 |-> {w[10], w[13], x[1], x[4], x[8]} == 5'h00; endproperty
	a_vel: assert property (p_vel) else $error("velocity foreign bits");
	property p_trq; displayedMode == 8'h0a |-> {w[10], w[13], x[1], x[7], x[8]} == 5'h00; endproperty
	a_trq: assert property (p_trq) else $error("torque foreign bits");
	property p_stop; decelStop |-> !x[4] && !x[7] && (!w[12] || displayedMode inside {1, 6}); endproperty
	a_stop: assert property (p_stop) else $error("stop bits not cleared");
	property p_hold;
		decelStop && $past(decelStop) && displayedMode == 8'h06 && $past(displayedMode) == 8'h06
		|-> w[13:12] == $past(w[13:12]);
	endproperty
	a_hold: assert property (p_hold) else $error("homing bits moved");
	property p_off;
		run && !cause.servoOn |=> decelStop && !opEnabled && $stable(displayedMode);
	endproperty
	a_off: assert property (p_off) else $error("servo-off stop wrong");
	property p_rest;
		decelStop && clkEn && !modeWrite && !cause.faultActive && speedAbs < restThreshold
		|=> !decelStop ##0 displayedMode == 8'h00 ##0 $stable(commandedMode);
	endproperty
	a_rest: assert property (p_rest) else $error("rest not handled");
	property p_prohib;
		run && cause.servoOn && cause.mainPowerOk && !cause.drivePermit && !cause.homingRunning
		|=> decelStop && opEnabled;
	endproperty
	a_prohib: assert property (p_prohib) else $error("prohibition stop wrong");
	property p_homing;
		run && cause.servoOn && cause.mainPowerOk && cause.homingRunning && commandedMode == 8'h06
		|=> !decelStop;
	endproperty
	a_homing: assert property (p_homing) else $error("homing run stopped");
	property p_fault; clkEn && cause.faultActive |=> displayedMode == 8'h00; endproperty
	a_fault: assert property (p_fault) else $error("fault display not zero");
	c_hold: cover property (decelStop && displayedMode == 8'h06);
	c_off: cover property (run && !cause.servoOn);
	c_fault: cover property (cause.faultActive);
endmodule : mdsb_status_bits_monitor

bind mdsb_status_bits mdsb_status_bits_monitor #(.SPEED_W(SPEED_W)) i_mdsb_status_bits_monitor (
	.ref_clk(ref_clk), .rst(rst), .clkEn(clkEn), .modeWrite(modeWrite),
	.modeWriteData(modeWriteData), .cause(cause), .src(src), .speedAbs(speedAbs),
	.restThreshold(restThreshold), .driveStatusWord(driveStatusWord),
	.driveStatusExtension(driveStatusExtension), .commandedMode(commandedMode),
	.displayedMode(displayedMode), .opEnabled(opEnabled), .decelStop(decelStop)
);

//--- bench/tb.sv
// Purpose: sequence tests of the mode-dependent status bits
// Assumes: inputs change 1 ns after the rising edge
// Notes: expected bits packed as {b13,b12,b10,close,match,limit,done}
`timescale 1ns/1ps
module tb;
	logic ref_clk, rst, clkEn, req, modeWrite, opEnabled, decelStop;
	logic [7:0] reqMode, modeWriteData, cmdMode, dispMode;
	logic [15:0] speedAbs, restThreshold, word, ext;
	mdsb_pkg::mdsb_cause_t cause;
	mdsb_pkg::mdsb_src_t src;
	int err_count = 0;
	int n_compared = 0;
	logic [7:0] modes [6] = '{8'h01, 8'h06, 8'h08, 8'h09, 8'h0a, 8'h00};
	logic [6:0] runTab [6] = '{7'h58, 7'h38, 7'h68, 7'h24, 7'h22, 7'h09};
	logic [6:0] stopTab [6] = '{7'h58, 7'h38, 7'h48, 7'h00, 7'h00, 7'h09};

	mdsb_status_bits i_mdsb_status_bits (.ref_clk(ref_clk), .rst(rst), .clkEn(clkEn),
		.modeWrite(modeWrite), .modeWriteData(modeWriteData), .cause(cause), .src(src),
		.speedAbs(speedAbs), .restThreshold(restThreshold), .driveStatusWord(word),
		.driveStatusExtension(ext), .commandedMode(cmdMode), .displayedMode(dispMode),
		.opEnabled(opEnabled), .decelStop(decelStop));
	mdsb_master_model i_mdsb_master_model (.ref_clk(ref_clk), .rst(rst), .req(req),
		.reqMode(reqMode), .modeWrite(modeWrite), .modeWriteData(modeWriteData));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	task automatic step(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : step
	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	function automatic logic [31:0] words(input logic [6:0] c);
		return {2'h0, c[6], c[5], 1'b0, c[4], 10'h200, 7'h00, c[3], c[2], 2'h0, c[1], 2'h0, c[0], 1'b0};
	endfunction : words
	// the master write lands one edge after the request, the outputs one more
	task automatic setMode(input logic [7:0] m);
		req = 1'b1;
		reqMode = m;
		step(1);
		req = 1'b0;
		step(2);
	endtask : setMode
	task automatic conclude();
		if (err_count == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : conclude
	// the whole run needs well under 200 cycles, so 10000 means a hang
	initial begin
		#100000;
		err_count++;
		conclude();
	end

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		{rst, clkEn, req, reqMode} = {1'b1, 1'b1, 1'b0, 8'h00};
		cause = 5'b11100;
		src = 10'b1011100111;
		speedAbs = 16'h0100;
		restThreshold = 16'h0010;
		repeat (12) @(posedge ref_clk);
		#1 rst = 1'b0;
		check("reset", {word, ext}, 32'h02000102);
		foreach (modes[i]) begin
			setMode(modes[i]);
			check("run bits", {word, ext}, words(runTab[i]));
			cause.servoOn = 1'b0;
			src.homeAttained = 1'b0;
			src.homingError = 1'b1;
			step(1);
			check("stop bits", {word, ext}, words(stopTab[i]));
			check("stop mode", {decelStop, opEnabled, dispMode}, {2'b10, modes[i]});
			speedAbs = 16'h0008;
			step(1);
			check("rest", {dispMode, cmdMode, decelStop}, {8'h00, modes[i], 1'b0});
			speedAbs = 16'h0100;
			cause.servoOn = 1'b1;
			src = 10'b1011100111;
			step(1);
		end
		setMode(8'h08);
		cause.drivePermit = 1'b0;
		step(1);
		check("prohibit", {decelStop, opEnabled, dispMode}, {2'b11, 8'h08});
		cause.drivePermit = 1'b1;
		speedAbs = 16'h0008;
		step(1);
		check("prohibit rest", {decelStop, opEnabled, dispMode, cmdMode}, {2'b00, 8'h00, 8'h08});
		speedAbs = 16'h0100;
		setMode(8'h06);
		cause.homingRunning = 1'b1;
		cause.drivePermit = 1'b0;
		step(2);
		check("homing run", decelStop, 1'b0);
		cause.mainPowerOk = 1'b0;
		step(1);
		check("power loss", {decelStop, dispMode}, {1'b1, 8'h06});
		clkEn = 1'b0;
		speedAbs = 16'h0008;
		src.homeAttained = 1'b0;
		src.homingError = 1'b1;
		step(2);
		check("freeze", {decelStop, opEnabled, dispMode, word}, {2'b10, 8'h06, 16'h1600});
		clkEn = 1'b1;
		speedAbs = 16'h0100;
		step(1);
		check("homing hold", word, 16'h1600);
		cause.faultActive = 1'b1;
		step(1);
		check("fault", {dispMode, word, ext}, {8'h00, 32'h02000102});
		rst = 1'b1;
		step(2);
		rst = 1'b0;
		check("second reset", {word, ext, cmdMode, opEnabled}, {32'h02000102, 8'h00, 1'b0});
		step(2);
		check("fault after reset", {dispMode, decelStop}, {8'h00, 1'b0});
		conclude();
	end
endmodule : tb
